// File: design/scss_clock_switch.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module scss_clock_switch #(
   parameter logic [3:0] SWITCH_TICKS = scss_pkg::SWITCH_TICKS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Register port
   input wire scss_pkg::scss_bus_req_t bus_req,
   output logic [7:0] rd_data,
   // Core events
   input wire logic sleep_exec,
   input wire logic wake_event,
   input wire logic watchdog_enable,
   // Configuration
   input wire logic internal_external_switchover,
   input wire logic [3:0] cfg_primary_mode,
   output logic [3:0] primary_mode,
   // Oscillator status and ticks
   input wire logic startup_done,
   input wire logic fast_internal_ready,
   input wire scss_pkg::scss_osc_t osc_tick,
   // Oscillator enables
   output scss_pkg::scss_osc_t osc_en,
   // System clock ticks
   output logic sys_tick,
   output logic cpu_tick,
   output logic periph_tick
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   scss_pkg::scss_state_t q;
   scss_pkg::scss_state_t d;
   logic int_div_tick;
   logic int_tick;
   logic settled;
   logic primary_ready_flag;
   logic fast_internal_stable_flag;
   logic secondary_running_flag;
   logic new_tick;
   scss_pkg::scss_src_t cur;
   scss_pkg::scss_src_t req_src;

   // ---------------------------------------------------------------
   // Internal block frequency path
   // ---------------------------------------------------------------
   scss_postscaler u_post (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .fast_tick(osc_tick.fast),
      .freq_sel(q.freq),
      .div_tick(int_div_tick)
   );

   always_comb begin
      if (q.freq == scss_pkg::FREQ_SLOW_DIRECT) begin
         int_tick = osc_tick.slow;
      end
      else if (q.freq == scss_pkg::FREQ_FAST_DIRECT) begin
         int_tick = osc_tick.fast;
      end
      else begin
         int_tick = int_div_tick;
      end
   end

   function automatic logic src_tick(input scss_pkg::scss_src_t s,
                                     input scss_pkg::scss_osc_t t,
                                     input logic it);
      unique case (s)
         scss_pkg::SRC_PRI: return t.pri;
         scss_pkg::SRC_SEC: return t.sec;
         scss_pkg::SRC_INT: return it;
         default: return 1'b0;
      endcase
   endfunction : src_tick

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   assign settled = (q.st == scss_pkg::ST_RUN) ||
                    (q.st == scss_pkg::ST_MANAGED);
   assign cur = (q.st == scss_pkg::ST_SWITCH) ? q.tgt : q.act;
   assign req_src = scss_pkg::scss_decode_csel(q.csel);
   assign new_tick = src_tick(q.tgt, osc_tick, int_tick);

   always_comb begin
      if (q.st == scss_pkg::ST_INIT) begin
         primary_ready_flag = ~internal_external_switchover;
      end
      else begin
         primary_ready_flag = settled && startup_done &&
                              (q.act == scss_pkg::SRC_PRI);
      end
   end

   assign fast_internal_stable_flag = settled && fast_internal_ready &&
      (q.act == scss_pkg::SRC_INT) &&
      (q.freq != scss_pkg::FREQ_SLOW_DIRECT);
   assign secondary_running_flag = settled &&
      (q.act == scss_pkg::SRC_SEC);

   // ---------------------------------------------------------------
   // Clock gating and enables
   // ---------------------------------------------------------------
   assign sys_tick = settled && src_tick(q.act, osc_tick, int_tick);
   assign cpu_tick = sys_tick &&
      !((q.st == scss_pkg::ST_MANAGED) && q.idle_pm);
   assign periph_tick = sys_tick;

   always_comb begin
      osc_en.pri = (q.st != scss_pkg::ST_SLEEP) &&
                   (cur == scss_pkg::SRC_PRI);
      osc_en.fast = (q.st != scss_pkg::ST_SLEEP) &&
                    (cur == scss_pkg::SRC_INT) &&
                    (q.freq != scss_pkg::FREQ_SLOW_DIRECT);
      osc_en.slow = watchdog_enable ||
                    ((q.st != scss_pkg::ST_SLEEP) &&
                     (cur == scss_pkg::SRC_INT));
      osc_en.sec = q.t1[scss_pkg::BIT_SEC_EN];
   end

   assign primary_mode = q.pri_mode;
   assign rd_data = q.rd_data;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.rd_data = 8'h00;
      // Register writes
      if (bus_req.wr && (bus_req.addr == scss_pkg::OFS_OSC_CTL)) begin
         d.idle = bus_req.wdata[scss_pkg::BIT_IDLE];
         d.freq = bus_req.wdata[scss_pkg::FREQ_LSB +: 3];
         d.csel = bus_req.wdata[scss_pkg::CSEL_LSB +: 2];
      end
      if (bus_req.wr && (bus_req.addr == scss_pkg::OFS_TMR1_CTL)) begin
         d.t1 = bus_req.wdata;
         d.t1[scss_pkg::BIT_SECONDARY_RUN_MODE] = 1'b0;
      end
      // Register reads
      if (bus_req.rd) begin
         if (bus_req.addr == scss_pkg::OFS_OSC_CTL) begin
            d.rd_data = {q.idle, q.freq, primary_ready_flag,
                         fast_internal_stable_flag, q.csel};
         end
         else if (bus_req.addr == scss_pkg::OFS_TMR1_CTL) begin
            d.rd_data = q.t1;
            d.rd_data[scss_pkg::BIT_SECONDARY_RUN_MODE] = secondary_running_flag;
         end
      end
      // Mode sequencing
      unique case (q.st)
         scss_pkg::ST_INIT: begin
            d.pri_mode = cfg_primary_mode;
            d.act = scss_pkg::SRC_PRI;
            d.st = scss_pkg::ST_RUN;
         end
         scss_pkg::ST_RUN, scss_pkg::ST_MANAGED: begin
            if (wake_event && (q.st == scss_pkg::ST_MANAGED)) begin
               d.tgt = scss_pkg::SRC_PRI;
               d.dest_pm = 1'b0;
               d.cnt = scss_pkg::CNT_RST;
               d.st = scss_pkg::ST_SWITCH;
            end
            else if (sleep_exec) begin
               if ((req_src == scss_pkg::SRC_SEC) &&
                   !q.t1[scss_pkg::BIT_SEC_EN]) begin
                  d.st = q.st;
               end
               else if (!q.idle && (q.csel == scss_pkg::CSEL_PRI)) begin
                  d.st = scss_pkg::ST_SLEEP;
               end
               else if (req_src == q.act) begin
                  d.idle_pm = q.idle;
                  d.st = scss_pkg::ST_MANAGED;
               end
               else begin
                  d.tgt = req_src;
                  d.dest_pm = 1'b1;
                  d.idle_pm = q.idle;
                  d.cnt = scss_pkg::CNT_RST;
                  d.st = scss_pkg::ST_SWITCH;
               end
            end
         end
         scss_pkg::ST_SWITCH: begin
            if (wake_event) begin
               d.tgt = scss_pkg::SRC_PRI;
               d.dest_pm = 1'b0;
               d.cnt = scss_pkg::CNT_RST;
            end
            else if (new_tick) begin
               if (q.cnt == SWITCH_TICKS - 4'h1) begin
                  d.act = q.tgt;
                  d.st = q.dest_pm ? scss_pkg::ST_MANAGED
                                   : scss_pkg::ST_RUN;
               end
               else begin
                  d.cnt = q.cnt + 4'h1;
               end
            end
         end
         scss_pkg::ST_SLEEP: begin
            if (wake_event) begin
               d.tgt = scss_pkg::SRC_PRI;
               d.dest_pm = 1'b0;
               d.cnt = scss_pkg::CNT_RST;
               d.st = scss_pkg::ST_SWITCH;
            end
         end
         default: begin
            d.st = scss_pkg::ST_INIT;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q.st <= scss_pkg::ST_INIT;
         q.act <= scss_pkg::SRC_PRI;
         q.tgt <= scss_pkg::SRC_PRI;
         q.dest_pm <= 1'b0;
         q.idle_pm <= 1'b0;
         q.idle <= scss_pkg::OSC_CTL_RST[scss_pkg::BIT_IDLE];
         q.freq <= scss_pkg::FREQ_RST;
         q.csel <= scss_pkg::CSEL_RST;
         q.t1 <= scss_pkg::TMR1_CTL_RST;
         q.cnt <= scss_pkg::CNT_RST;
         q.pri_mode <= scss_pkg::PRI_MODE_RST;
         q.rd_data <= 8'h00;
      end
      else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_sel_hold;
      (q.st == scss_pkg::ST_RUN) && !sleep_exec |=> $stable(q.act);
   endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("source changed without sleep");

   property p_sec_decode;
      (q.st == scss_pkg::ST_RUN) && sleep_exec && (q.csel == 2'h1) &&
      q.t1[scss_pkg::BIT_SEC_EN] && (q.act == scss_pkg::SRC_PRI)
      |=> (q.st == scss_pkg::ST_SWITCH) && (q.tgt == scss_pkg::SRC_SEC);
   endproperty
   a_sec_decode: assert property (p_sec_decode)
      else $error("secondary select not taken");

   property p_sec_ignored;
      (q.st == scss_pkg::ST_RUN) && sleep_exec && (q.csel == 2'h1) &&
      !q.t1[scss_pkg::BIT_SEC_EN] |=> (q.st == scss_pkg::ST_RUN);
   endproperty
   a_sec_ignored: assert property (p_sec_ignored)
      else $error("secondary select not ignored");

   property p_pause_end;
      (q.st == scss_pkg::ST_SWITCH) && new_tick && !wake_event &&
      (q.cnt == SWITCH_TICKS - 4'h1) |=> settled && (q.act == $past(q.tgt));
   endproperty
   a_pause_end: assert property (p_pause_end)
      else $error("switch pause did not end");

   property p_pause_quiet;
      (q.st == scss_pkg::ST_SWITCH) |-> !sys_tick && !cpu_tick;
   endproperty
   a_pause_quiet: assert property (p_pause_quiet)
      else $error("clock ran during pause");

   property p_one_flag;
      (q.st != scss_pkg::ST_INIT) |-> $onehot0({primary_ready_flag,
         fast_internal_stable_flag, secondary_running_flag});
   endproperty
   a_one_flag: assert property (p_one_flag)
      else $error("more than one source flag");

   property p_pri_ready;
      primary_ready_flag && (q.st != scss_pkg::ST_INIT)
      |-> startup_done && (q.act == scss_pkg::SRC_PRI);
   endproperty
   a_pri_ready: assert property (p_pri_ready)
      else $error("primary ready without cause");

   property p_slow_only;
      (q.freq == scss_pkg::FREQ_SLOW_DIRECT) &&
      (cur == scss_pkg::SRC_INT) |-> !osc_en.fast;
   endproperty
   a_slow_only: assert property (p_slow_only)
      else $error("fast output on with slow direct");

   property p_sleep_stop;
      (q.st == scss_pkg::ST_SLEEP) |-> !osc_en.pri && !osc_en.fast &&
      (osc_en.slow == watchdog_enable) && !sys_tick;
   endproperty
   a_sleep_stop: assert property (p_sleep_stop)
      else $error("source running in sleep");

   property p_wdt_slow;
      watchdog_enable |-> osc_en.slow;
   endproperty
   a_wdt_slow: assert property (p_wdt_slow)
      else $error("slow source off with watchdog");

   property p_wake;
      ((q.st == scss_pkg::ST_MANAGED) || (q.st == scss_pkg::ST_SLEEP)) &&
      wake_event |=> (q.st == scss_pkg::ST_SWITCH) &&
      (q.tgt == scss_pkg::SRC_PRI) ##1 !q.dest_pm;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake did not return to primary");

   property p_idle_cpu;
      (q.st == scss_pkg::ST_MANAGED) && q.idle_pm |-> !cpu_tick;
   endproperty
   a_idle_cpu: assert property (p_idle_cpu)
      else $error("cpu clocked in idle mode");

   c_sleep: cover property ((q.st == scss_pkg::ST_RUN) ##1
                            (q.st == scss_pkg::ST_SLEEP));
   c_sec_mode: cover property (secondary_running_flag);
   c_int_mode: cover property (fast_internal_stable_flag);
   c_wake: cover property ((q.st == scss_pkg::ST_MANAGED) && wake_event);

endmodule : scss_clock_switch

// File: design/scss_pkg.sv
package scss_pkg;

   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam int unsigned REG_AW = 2;
   localparam logic [REG_AW-1:0] OFS_OSC_CTL = 2'h0;
   localparam logic [REG_AW-1:0] OFS_TMR1_CTL = 2'h1;
   localparam logic [7:0] OSC_CTL_RST = 8'h00;
   localparam logic [7:0] TMR1_CTL_RST = 8'h00;
   localparam int unsigned BIT_IDLE = 7;
   localparam int unsigned FREQ_LSB = 4;
   localparam int unsigned BIT_PRI_RDY = 3;
   localparam int unsigned BIT_FAST_STB = 2;
   localparam int unsigned CSEL_LSB = 0;
   localparam int unsigned BIT_SECONDARY_RUN_MODE = 6;
   localparam int unsigned BIT_SEC_EN = 3;

   // ---------------------------------------------------------------
   // Codes and counts
   // ---------------------------------------------------------------
   localparam logic [2:0] FREQ_FAST_DIRECT = 3'h7;
   localparam logic [2:0] FREQ_SLOW_DIRECT = 3'h0;
   localparam logic [2:0] FREQ_RST = 3'h0;
   localparam logic [1:0] CSEL_PRI = 2'h0;
   localparam logic [1:0] CSEL_RST = 2'h0;
   localparam logic [3:0] SWITCH_TICKS = 4'h8;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] PRI_MODE_RST = 4'h0;
   localparam logic [5:0] DIV_RST = 6'h00;

   typedef enum logic [1:0] {
      SRC_PRI = 2'b00,
      SRC_SEC = 2'b01,
      SRC_INT = 2'b10
   } scss_src_t;

   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_RUN = 3'b001,
      ST_SWITCH = 3'b010,
      ST_MANAGED = 3'b011,
      ST_SLEEP = 3'b100
   } scss_st_t;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [REG_AW-1:0] addr;
      logic [7:0] wdata;
   } scss_bus_req_t;

   typedef struct packed {
      logic pri;
      logic sec;
      logic fast;
      logic slow;
   } scss_osc_t;

   typedef struct packed {
      scss_st_t st;
      scss_src_t act;
      scss_src_t tgt;
      logic dest_pm;
      logic idle_pm;
      logic idle;
      logic [2:0] freq;
      logic [1:0] csel;
      logic [7:0] t1;
      logic [3:0] cnt;
      logic [3:0] pri_mode;
      logic [7:0] rd_data;
   } scss_state_t;

   typedef struct packed {
      logic [5:0] div;
   } scss_post_t;

   function automatic scss_src_t scss_decode_csel(input logic [1:0] c);
      if (c[1]) begin
         return SRC_INT;
      end
      else if (c[0]) begin
         return SRC_SEC;
      end
      return SRC_PRI;
   endfunction : scss_decode_csel

endpackage : scss_pkg

// File: design/scss_postscaler.sv
`timescale 1ns/1ps
module scss_postscaler (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Fast source tick and selection
   input wire logic fast_tick,
   input wire logic [2:0] freq_sel,
   // Divided tick
   output logic div_tick
);

   // ---------------------------------------------------------------
   // Divider state
   // ---------------------------------------------------------------
   scss_pkg::scss_post_t q;
   scss_pkg::scss_post_t d;

   function automatic logic [5:0] div_mask(input logic [2:0] s);
      logic [6:0] m;
      m = (7'h01 << (3'h7 - s)) - 7'h01;
      return m[5:0];
   endfunction : div_mask

   always_comb begin
      d = q;
      if (fast_tick) begin
         d.div = q.div + 6'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q.div <= scss_pkg::DIV_RST;
      end
      else begin
         q <= d;
      end
   end

   // Takes effect on the very next tick after a selection change
   assign div_tick = fast_tick &&
      ((q.div & div_mask(freq_sel)) == div_mask(freq_sel));

endmodule : scss_postscaler

// File: test/scss_tb.sv
`timescale 1ns/1ps
module tb;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   scss_pkg::scss_bus_req_t bus_req = '0;
   logic [7:0] rd_data;
   logic sleep_exec = 1'b0;
   logic wake_event = 1'b0;
   logic watchdog_enable = 1'b1;
   logic internal_external_switchover = 1'b0;
   logic [3:0] cfg_primary_mode = 4'h5;
   logic [3:0] primary_mode;
   logic startup_done = 1'b1;
   logic fast_internal_ready = 1'b1;
   scss_pkg::scss_osc_t osc_tick = '0;
   scss_pkg::scss_osc_t osc_en;
   logic sys_tick;
   logic cpu_tick;
   logic periph_tick;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   int tc = 0;

   // ---------------------------------------------------------------
   // Clock, source ticks and design
   // ---------------------------------------------------------------
   always #50 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      tc <= tc + 1;
      osc_tick.pri <= (tc % 2 == 0);
      osc_tick.sec <= (tc % 5 == 0);
      osc_tick.fast <= (tc % 3 == 0);
      osc_tick.slow <= (tc % 7 == 0);
   end

   scss_clock_switch #(.SWITCH_TICKS(4'h8)) DUT (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .sleep_exec(sleep_exec),
      .wake_event(wake_event),
      .watchdog_enable(watchdog_enable),
      .internal_external_switchover(internal_external_switchover),
      .cfg_primary_mode(cfg_primary_mode),
      .primary_mode(primary_mode),
      .startup_done(startup_done),
      .fast_internal_ready(fast_internal_ready),
      .osc_tick(osc_tick),
      .osc_en(osc_en),
      .sys_tick(sys_tick),
      .cpu_tick(cpu_tick),
      .periph_tick(periph_tick)
   );

   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end
      else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         report_and_stop();
      end
   end

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_en(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : chk_en

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= d;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask : wr_reg

   task automatic chk_rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      @(negedge core_clk);
      chk_reg(rd_data, exp);
   endtask : chk_rd

   task automatic pulse(input bit wake);
      @(posedge core_clk);
      if (wake) sleep_exec <= 1'b0;
      if (wake) wake_event <= 1'b1;
      else sleep_exec <= 1'b1;
      @(posedge core_clk);
      sleep_exec <= 1'b0;
      wake_event <= 1'b0;
   endtask : pulse

   function automatic logic pick(input int w);
      case (w)
         0: return osc_tick.pri;
         1: return osc_tick.sec;
         2: return osc_tick.fast;
         3: return osc_tick.slow;
         default: return 1'b0;
      endcase
   endfunction : pick

   // Ticks must follow the chosen source; CPU ticks only when run
   task automatic watch(input int n, input int w, input logic cpu_on);
      logic e;
      repeat (n) begin
         @(negedge core_clk);
         e = pick(w);
         chk_bit(sys_tick, e);
         chk_bit(cpu_tick, e & cpu_on);
         chk_bit(periph_tick, e);
      end
   endtask : watch

   // Counts new source ticks seen before the first system tick
   task automatic wait_switch(input int w);
      int k;
      int t;
      k = 0;
      for (t = 0; t < 400; t++) begin
         @(negedge core_clk);
         if (sys_tick === 1'b1) break;
         if (pick(w)) k++;
      end
      chk_bit(k >= 8 && k <= 9, 1'b1);
   endtask : wait_switch

   // Counts system ticks over a window of whole fast source periods
   task automatic chk_rate(input int n, input int exp);
      int s;
      s = 0;
      repeat (n) begin
         @(negedge core_clk);
         if (sys_tick === 1'b1) s++;
      end
      chk_reg(s[7:0], exp[7:0]);
   endtask : chk_rate

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      chk_en(osc_en, 4'b1001);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      cfg_primary_mode <= 4'hA;
      repeat (2) @(negedge core_clk);
      chk_reg({4'h0, primary_mode}, 8'h05);
      chk_rd(2'h0, 8'h08);
      chk_rd(2'h1, 8'h00);
      chk_rd(2'h2, 8'h00);
      @(posedge core_clk);
      startup_done <= 1'b0;
      chk_rd(2'h0, 8'h00);
      @(posedge core_clk);
      startup_done <= 1'b1;
      // Read-only flags, unmapped place, select held back
      wr_reg(2'h0, 8'hFF);
      chk_rd(2'h0, 8'hFB);
      wr_reg(2'h1, 8'h40);
      chk_rd(2'h1, 8'h00);
      wr_reg(2'h3, 8'hFF);
      chk_rd(2'h3, 8'h00);
      watch(12, 0, 1'b1);
      // Secondary asked for while its oscillator is off
      wr_reg(2'h0, 8'h11);
      pulse(1'b0);
      watch(12, 0, 1'b1);
      chk_bit(osc_en.pri, 1'b1);
      // Secondary idle
      wr_reg(2'h1, 8'h08);
      wr_reg(2'h0, 8'h81);
      pulse(1'b0);
      wait_switch(1);
      watch(20, 1, 1'b0);
      chk_rd(2'h1, 8'h48);
      chk_rd(2'h0, 8'h81);
      chk_bit(osc_en.pri, 1'b0);
      chk_bit(osc_en.sec, 1'b1);
      pulse(1'b1);
      wait_switch(0);
      watch(10, 0, 1'b1);
      chk_rd(2'h0, 8'h89);
      // Internal run, then the stable flag follows fast internal ready
      wr_reg(2'h0, 8'h72);
      pulse(1'b0);
      wait_switch(2);
      watch(15, 2, 1'b1);
      chk_rd(2'h0, 8'h76);
      chk_bit(osc_en.pri, 1'b0);
      @(posedge core_clk);
      fast_internal_ready <= 1'b0;
      chk_rd(2'h0, 8'h72);
      @(posedge core_clk);
      fast_internal_ready <= 1'b1;
      // Postscaled rates: 2 MHz is one tick in four, 125 kHz one in 64
      wr_reg(2'h0, 8'h52);
      chk_rate(36, 3);
      chk_rd(2'h0, 8'h56);
      wr_reg(2'h0, 8'h12);
      chk_rate(192, 1);
      wr_reg(2'h0, 8'h02);
      watch(21, 3, 1'b1);
      chk_bit(osc_en.fast, 1'b0);
      chk_rd(2'h0, 8'h02);
      pulse(1'b1);
      wait_switch(0);
      // Sleep, with and without the watchdog
      wr_reg(2'h0, 8'h00);
      watchdog_enable <= 1'b0;
      pulse(1'b0);
      watch(10, 4, 1'b0);
      chk_en(osc_en, 4'b0100);
      @(posedge core_clk);
      watchdog_enable <= 1'b1;
      @(negedge core_clk);
      chk_en(osc_en, 4'b0101);
      pulse(1'b1);
      wait_switch(0);
      // Primary idle keeps the primary running
      wr_reg(2'h0, 8'h80);
      pulse(1'b0);
      repeat (2) @(negedge core_clk);
      watch(10, 0, 1'b0);
      chk_bit(osc_en.pri, 1'b1);
      chk_rd(2'h0, 8'h88);
      pulse(1'b1);
      repeat (30) @(negedge core_clk);
      watch(10, 0, 1'b1);
      // Mid-run reset: select clears, ready flag follows switchover
      wr_reg(2'h0, 8'h73);
      rst_b <= 1'b0;
      internal_external_switchover <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      bus_req.rd <= 1'b1;
      bus_req.addr <= 2'h0;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      @(negedge core_clk);
      chk_reg(rd_data, 8'h00);
      chk_reg({4'h0, primary_mode}, 8'h0A);
      chk_rd(2'h0, 8'h08);
      report_and_stop();
   end
endmodule : tb
